/* File: dv/qbsp_ctrl_model.sv */
// Purpose: Memory controller model driving the SRAM port pins.
// Assumes: Called at a falling clk_sys edge; one call is one link period.
// Notes:   The link clock stands still between calls; unused data shows inverted.
`timescale 1ns/1ps
module qbsp_ctrl_model
  import qbsp_pkg::*;
(
  // Clock
  input  wire logic              clk_sys,
  // Pins toward the device
  output qbsp_pins_type          pins,
  // Answers from the device
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_out_oe,
  input  wire logic              read_data_valid
);
  logic [DATA_W-1:0] q0 [64];
  logic [DATA_W-1:0] q1 [64];
  logic              vk [64];
  logic              ok [64];
  int                cyc = 0;
  initial begin
    pins = '0;
    pins.k_clk_n = 1'b1;
    pins.read_port_select_n = 1'b1;
    pins.write_port_select_n = 1'b1;
    pins.pll_disable_n = 1'b1;
  end
  // Every pin change sits two clk_sys cycles from the nearest link edge.
  task automatic cycle(input logic rd, wr, input logic [ADDR_W-1:0] ra, wa,
                       input logic [DATA_W-1:0] w0, w1, input logic [NBYTES-1:0] b0, b1);
    pins.read_port_select_n = !rd;
    pins.write_port_select_n = !wr;
    pins.addr = rd ? ra : ~pins.addr;
    pins.data = wr ? w0 : ~pins.data;
    pins.byte_write_select_n = wr ? b0 : ~pins.byte_write_select_n;
    repeat (2) @(negedge clk_sys);
    pins.k_clk = 1'b1;
    pins.k_clk_n = 1'b0;
    q1[(cyc + 63) % 64] = data_out;
    vk[cyc % 64] = read_data_valid;
    ok[cyc % 64] = data_out_oe;
    repeat (2) @(negedge clk_sys);
    pins.read_port_select_n = 1'b1;
    pins.write_port_select_n = 1'b1;
    pins.addr = wa;
    pins.data = wr ? w1 : ~pins.data;
    pins.byte_write_select_n = wr ? b1 : ~pins.byte_write_select_n;
    repeat (2) @(negedge clk_sys);
    pins.k_clk = 1'b0;
    pins.k_clk_n = 1'b1;
    q0[cyc % 64] = data_out;
    repeat (2) @(negedge clk_sys);
    cyc++;
  endtask : cycle
endmodule : qbsp_ctrl_model

/* File: dv/qbsp_sram_port_properties.sv */
// Purpose: Pin timing checks for the burst-of-two SRAM port.
// Assumes: Bound to qbsp_sram_port; all checks run on clk_sys.
// Notes:   Link clock rises are counted at the raw pin.
`timescale 1ns/1ps
module qbsp_sram_port_properties
  import qbsp_pkg::*;
#(
  parameter int unsigned LOCK_CYC  = PLL_LOCK_CYC,
  parameter int unsigned STALL_CYC = 16,
  parameter int unsigned RECAL_CYC = RECAL_PERIOD
) (
  // System
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // Pins
  input wire logic       k_clk,
  input wire logic       k_clk_n,
  input wire logic       read_port_select_n,
  input wire logic       pll_disable_n,
  // Answers
  input wire logic       data_out_oe,
  input wire logic       read_data_valid,
  input wire logic [1:0] echo_clock_out,
  input wire logic       pll_locked,
  input wire logic       impedance_cal_strobe
);
  logic        k_q;
  logic [2:0]  gap_q;
  logic [15:0] rises_q;
  logic        seen_q;
  logic [15:0] on_q;
  wire         k_rise = k_clk & ~k_q;
  always_ff @(posedge clk_sys) begin
    k_q <= k_clk;
  end
  // Four link rises after the last read nothing may still be pending.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gap_q <= 3'h4;
    end else if (k_rise && !read_port_select_n) begin
      gap_q <= 3'h0;
    end else if (k_rise && gap_q != 3'h4) begin
      gap_q <= gap_q + 3'h1;
    end
  end
  // The first strobe after reset has no reference and is not judged.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rises_q <= 16'h0000;
      seen_q  <= 1'b0;
    end else begin
      rises_q <= impedance_cal_strobe ? {15'h0000, k_rise} : rises_q + {15'h0000, k_rise};
      seen_q  <= seen_q | impedance_cal_strobe;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !pll_disable_n) begin
      on_q <= 16'h0000;
    end else if (on_q != 16'hffff) begin
      on_q <= on_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_valid_half;
    read_data_valid[*8];
  endsequence
  sequence s_drive_burst;
    data_out_oe[*8];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    !data_out_oe && !read_data_valid && !pll_locked && echo_clock_out == 2'b00) else $error("busy after reset");
  a_echo_pos: assert property ($rose(k_clk) |-> ##[2:5] $rose(echo_clock_out[0])) else $error("echo pos");
  a_echo_neg: assert property ($rose(k_clk_n) |-> ##[2:5] $rose(echo_clock_out[1])) else $error("echo neg");
  a_recal_period: assert property (
    impedance_cal_strobe && seen_q |-> rises_q == RECAL_CYC) else $error("recal period");
  a_valid_half: assert property ($rose(read_data_valid) |-> s_valid_half) else $error("valid width");
  a_drive_follows: assert property ($rose(read_data_valid) |-> ##4 s_drive_burst) else $error("drive late");
  a_idle_quiet: assert property (
    gap_q == 3'h4 |-> !data_out_oe && !read_data_valid) else $error("drive without read");
  a_lock_wait: assert property ($rose(pll_locked) |-> on_q >= LOCK_CYC) else $error("lock early");
endmodule : qbsp_sram_port_properties
bind qbsp_sram_port qbsp_sram_port_properties #(
  .LOCK_CYC(LOCK_CYC), .STALL_CYC(STALL_CYC), .RECAL_CYC(RECAL_CYC)
) u_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .k_clk(k_clk), .k_clk_n(k_clk_n),
  .read_port_select_n(read_port_select_n), .pll_disable_n(pll_disable_n), .data_out_oe(data_out_oe),
  .read_data_valid(read_data_valid), .echo_clock_out(echo_clock_out), .pll_locked(pll_locked),
  .impedance_cal_strobe(impedance_cal_strobe)
);

/* File: dv/qbsp_sram_port_tb.sv */
// Purpose: Self-checking bench for the burst-of-two SRAM port.
// Assumes: Link period of 160 ns, eight clk_sys cycles.
// Notes:   Lock and recalibration counts are shortened by parameters.
`timescale 1ns/1ps
module qbsp_sram_port_tb
  import qbsp_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  qbsp_pins_type     pins;
  logic [DATA_W-1:0] data_out;
  logic              data_out_oe;
  logic              read_data_valid;
  logic              pll_locked;
  logic              min_impedance_mode;
  logic [DATA_W-1:0] exp_mem [WORDS];
  int                errors = 0;
  int                checks_done = 0;
  always #10 clk_sys = ~clk_sys;
  qbsp_sram_port #(.LOCK_CYC(50), .STALL_CYC(16), .RECAL_CYC(8)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .k_clk(pins.k_clk), .k_clk_n(pins.k_clk_n), .addr(pins.addr),
    .read_port_select_n(pins.read_port_select_n), .write_port_select_n(pins.write_port_select_n),
    .byte_write_select_n(pins.byte_write_select_n), .pll_disable_n(pins.pll_disable_n),
    .impedance_ref_pin(pins.impedance_ref_pin), .data_in(pins.data), .data_out(data_out),
    .data_out_oe(data_out_oe), .read_data_valid(read_data_valid), .echo_clock_out(),
    .pll_locked(pll_locked), .impedance_cal_strobe(), .min_impedance_mode(min_impedance_mode));
  qbsp_ctrl_model ctrl (.clk_sys(clk_sys), .pins(pins), .data_out(data_out), .data_out_oe(data_out_oe),
    .read_data_valid(read_data_valid));
  task automatic chk(input string what, input logic [DATA_W-1:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [NBYTES-1:0] m);
    for (int i = 0; i < NBYTES; i++) begin
      if (!m[i]) o[i*BYTE_W +: BYTE_W] = n[i*BYTE_W +: BYTE_W];
    end
    return o;
  endfunction : merge
  task automatic op(input logic rd, wr, input logic [ADDR_W-1:0] ra, wa,
                    input logic [DATA_W-1:0] w0, w1, input logic [NBYTES-1:0] b0, b1);
    if (wr) begin
      exp_mem[{wa, 1'b0}] = merge(exp_mem[{wa, 1'b0}], w0, b0);
      exp_mem[{wa, 1'b1}] = merge(exp_mem[{wa, 1'b1}], w1, b1);
    end
    ctrl.cycle(rd, wr, ra, wa, w0, w1, b0, b1);
  endtask : op
  task automatic idle(input int n);
    repeat (n) ctrl.cycle(1'b0, 1'b0, '0, '0, '0, '0, '1, '1);
  endtask : idle
  task automatic rd_chk(input int t, input logic [ADDR_W-1:0] a);
    chk("word0", exp_mem[{a, 1'b0}], ctrl.q0[t % 64]);
    chk("word1", exp_mem[{a, 1'b1}], ctrl.q1[t % 64]);
    chk("valid", 18'h1, 18'(ctrl.vk[t % 64]));
  endtask : rd_chk
  task automatic sc_burst;
    int t;
    op(1'b0, 1'b1, '0, 4'h3, 18'h1a2b3, 18'h2c4d5, 2'b00, 2'b00);
    op(1'b0, 1'b1, '0, 4'h5, 18'h0f0f1, 18'h30e1c, 2'b00, 2'b00);
    t = ctrl.cyc;
    op(1'b1, 1'b1, 4'h6, 4'h6, 18'h15a5a, 18'h2a5a5, 2'b00, 2'b00);
    op(1'b1, 1'b0, 4'h3, '0, '0, '0, '1, '1);
    op(1'b1, 1'b0, 4'h5, '0, '0, '0, '1, '1);
    idle(4);
    rd_chk(t + 2, 4'h6);
    rd_chk(t + 3, 4'h3);
    rd_chk(t + 4, 4'h5);
    chk("drive_on", 18'h1, 18'(ctrl.ok[(t + 5) % 64]));
    chk("drive_off", 18'h0, 18'(ctrl.ok[(t + 6) % 64]));
  endtask : sc_burst
  task automatic sc_mask;
    int t;
    op(1'b0, 1'b1, '0, 4'h3, 18'h3ffff, 18'h3ffff, 2'b10, 2'b01);
    ctrl.cycle(1'b0, 1'b0, '0, 4'h5, 18'h3ffff, 18'h3ffff, 2'b00, 2'b00);
    t = ctrl.cyc;
    op(1'b1, 1'b0, 4'h3, '0, '0, '0, '1, '1);
    op(1'b1, 1'b0, 4'h5, '0, '0, '0, '1, '1);
    idle(3);
    rd_chk(t + 2, 4'h3);
    rd_chk(t + 3, 4'h5);
  endtask : sc_mask
  task automatic sc_legacy;
    int t;
    ctrl.pins.pll_disable_n = 1'b0;
    idle(1);
    t = ctrl.cyc;
    op(1'b1, 1'b0, 4'h6, '0, '0, '0, '1, '1);
    idle(3);
    rd_chk(t + 1, 4'h6);
    chk("legacy_off", 18'h0, 18'(ctrl.ok[(t + 3) % 64]));
  endtask : sc_legacy
  task automatic sc_lock;
    ctrl.pins.pll_disable_n = 1'b1;
    idle(4);
    chk("lock_early", 18'h0, 18'(pll_locked));
    idle(4);
    chk("lock", 18'h1, 18'(pll_locked));
    repeat (40) @(negedge clk_sys);
    chk("lock_lost", 18'h0, 18'(pll_locked));
    idle(8);
    chk("relock", 18'h1, 18'(pll_locked));
  endtask : sc_lock
  task automatic sc_recal;
    ctrl.pins.impedance_ref_pin = 1'b1;
    idle(10);
    chk("min_imp", 18'h1, 18'(min_impedance_mode));
    ctrl.pins.impedance_ref_pin = 1'b0;
    idle(10);
    chk("min_imp", 18'h0, 18'(min_impedance_mode));
  endtask : sc_recal
  task automatic give_verdict;
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk("oe_reset", 18'h0, 18'(data_out_oe));
    sc_burst();
    sc_mask();
    sc_legacy();
    sc_lock();
    sc_recal();
    give_verdict();
  end
endmodule : qbsp_sram_port_tb

/* File: hw/qbsp_sram_port.sv */
//------------------------------------------------------------------------------
// Purpose: Device-side logic of a burst-of-two SRAM with separate read and
//          write ports on one multiplexed address bus.
// Assumes: The complementary input clocks are much slower than clk_sys and are
//          sampled, not used as clocks; every pin passes two flip-flops.
// Notes:   Output drive strength is not modelled; the impedance logic only
//          schedules recalibration and captures the reference pin mode.
//
// Notes on behaviour
// - PLL on: read data after 2.5 cycles; the code drives it after 2.
// - PLL off: legacy mode, one cycle latency.
// - Transactions begin on positive clock rise only.
// - Low read select latches read address.
// - Every access moves two sequential words.
// - First word at K rise, second next K#.
// - Deselected read finishes, then tristates after K#.
// - Write select captures first word on K.
// - K# latches address, second word, commits both.
// - Deselected write finishes pending, then ignores inputs.
// - Byte selects mask each written word's bytes.
// - Read and write ports start independently.
// - Reads return newest data, with forwarding.
// - Selects sampled on K; ports independent.
// - Recalibrate impedance every 1024 clock cycles.
// - Two free-running echo clocks from inputs.
// - Read valid leads data by half cycle.
// - PLL locks 100 us after stable clock.
// - Stopped input clocks reset the PLL.
// - Power up deselected with outputs tristated.
//------------------------------------------------------------------------------
`timescale 1ns/1ps

module qbsp_sram_port
  import qbsp_pkg::*;
#(
  parameter int unsigned LOCK_CYC  = PLL_LOCK_CYC,
  parameter int unsigned STALL_CYC = 16,
  parameter int unsigned RECAL_CYC = RECAL_PERIOD
) (
  // System clock and reset
  input  wire  logic              clk_sys,
  input  wire  logic              sys_rst,
  // Input clock pair
  input  wire  logic              k_clk,
  input  wire  logic              k_clk_n,
  // Address and control
  input  wire  logic [ADDR_W-1:0] addr,
  input  wire  logic              read_port_select_n,
  input  wire  logic              write_port_select_n,
  input  wire  logic [NBYTES-1:0] byte_write_select_n,
  input  wire  logic              pll_disable_n,
  input  wire  logic              impedance_ref_pin,
  // Write data
  input  wire  logic [DATA_W-1:0] data_in,
  // Read data
  output logic       [DATA_W-1:0] data_out,
  output logic                    data_out_oe,
  output logic                    read_data_valid,
  // Echo clocks and status
  output logic       [1:0]        echo_clock_out,
  output logic                    pll_locked,
  output logic                    impedance_cal_strobe,
  output logic                    min_impedance_mode
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  qbsp_pins_type pins_raw;
  qbsp_pins_type pin_q;
  logic          k_rise;
  logic          kn_rise;

  assign pins_raw = '{k_clk: k_clk, k_clk_n: k_clk_n, addr: addr,
                      read_port_select_n: read_port_select_n,
                      write_port_select_n: write_port_select_n,
                      byte_write_select_n: byte_write_select_n, data: data_in,
                      pll_disable_n: pll_disable_n, impedance_ref_pin: impedance_ref_pin};

  // Clocks, controls and data share one delay, so their alignment is kept.
  qbsp_sync2 #(
    .WIDTH (PINS_W)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .din     (pins_raw),
    .dout    (pin_q)
  );

  // The edge history follows the pins during reset as well, so releasing
  // reset with the idle levels on the pins shows no false edge.
  qbsp_edge_detect u_k_edge (
    .clk_sys (clk_sys),
    .level   (pin_q.k_clk),
    .rise    (k_rise)
  );

  qbsp_edge_detect u_kn_edge (
    .clk_sys (clk_sys),
    .level   (pin_q.k_clk_n),
    .rise    (kn_rise)
  );

  // ---------------------------------------------------------------------------
  // Storage and byte merge
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [WORDS];

  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_w,
                                                    input logic [DATA_W-1:0] new_w,
                                                    input logic [NBYTES-1:0] be_n);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int b = 0; b < NBYTES; b++) begin
      if (!be_n[b]) begin
        res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction : merge_bytes

  // ---------------------------------------------------------------------------
  // Write port
  // ---------------------------------------------------------------------------
  qbsp_wr_first_type wr_first_q;
  logic              commit_en;
  logic [ADDR_W:0]   commit_idx0;
  logic [ADDR_W:0]   commit_idx1;
  logic [DATA_W-1:0] commit_w0;
  logic [DATA_W-1:0] commit_w1;

  // First word and its byte selects are taken on the K rise that starts it.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_first_q <= '0;
    end else if (k_rise) begin
      wr_first_q.pending <= ~pin_q.write_port_select_n;
      wr_first_q.data    <= pin_q.data;
      wr_first_q.be_n    <= pin_q.byte_write_select_n;
    end else if (kn_rise) begin
      wr_first_q.pending <= 1'b0;
    end
  end

  // The K# rise after a start supplies the address and the second word.
  assign commit_en   = kn_rise & wr_first_q.pending;
  assign commit_idx0 = {pin_q.addr, BURST_FIRST};
  assign commit_idx1 = {pin_q.addr, BURST_SECOND};
  assign commit_w0   = merge_bytes(mem_q[commit_idx0], wr_first_q.data, wr_first_q.be_n);
  assign commit_w1   = merge_bytes(mem_q[commit_idx1], pin_q.data, pin_q.byte_write_select_n);

  always_ff @(posedge clk_sys) begin
    if (commit_en) begin
      mem_q[commit_idx0] <= commit_w0;
      mem_q[commit_idx1] <= commit_w1;
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  qbsp_rd_entry_type rd_pipe_q [2];
  qbsp_rd_entry_type rd_launch;
  logic              rd_second_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [ADDR_W:0]   rd_idx0;
  logic [ADDR_W:0]   rd_idx1;
  logic [DATA_W-1:0] rd_word1;
  logic              pll_on_q;

  // The latency mode is taken once per K cycle, so the word and the valid flag
  // of one launch never use different modes while the mode pin moves.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pll_on_q <= 1'b0;
    end else if (k_rise) begin
      pll_on_q <= pin_q.pll_disable_n;
    end
  end

  // A request loaded on K(t) drives on K(t+2) with the PLL on, K(t+1) off.
  assign rd_launch = pll_on_q ? rd_pipe_q[1] : rd_pipe_q[0];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_pipe_q[0] <= RD_IDLE;
      rd_pipe_q[1] <= RD_IDLE;
    end else if (k_rise) begin
      rd_pipe_q[0] <= '{valid: ~pin_q.read_port_select_n, addr: pin_q.addr};
      rd_pipe_q[1] <= rd_pipe_q[0];
    end
  end

  assign rd_idx0 = {rd_launch.addr, BURST_FIRST};
  assign rd_idx1 = {rd_addr_q, BURST_SECOND};

  // A write committing on this very K# edge is forwarded to the read.
  always_comb begin
    rd_word1 = mem_q[rd_idx1];
    if (commit_en && (commit_idx1 == rd_idx1)) begin
      rd_word1 = commit_w1;
    end
  end

  // Array reads happen at drive time, so any earlier commit is already seen.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_out    <= '0;
      data_out_oe <= 1'b0;
      rd_second_q <= 1'b0;
      rd_addr_q   <= '0;
    end else if (k_rise) begin
      rd_second_q <= rd_launch.valid;
      rd_addr_q   <= rd_launch.addr;
      if (rd_launch.valid) begin
        data_out    <= mem_q[rd_idx0];
        data_out_oe <= 1'b1;
      end
    end else if (kn_rise) begin
      rd_second_q <= 1'b0;
      if (rd_second_q) begin
        data_out <= rd_word1;
      end else begin
        data_out_oe <= 1'b0;
      end
    end
  end

  // Valid rises on the K# before the first word and falls on the second one.
  // It looks at the request that the next K rise will launch, which is the
  // older pipeline entry while the PLL is on.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      read_data_valid <= 1'b0;
    end else if (kn_rise) begin
      read_data_valid <= rd_launch.valid;
    end
  end

  // ---------------------------------------------------------------------------
  // Echo clocks
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      echo_clock_out <= '0;
    end else begin
      echo_clock_out <= {pin_q.k_clk_n, pin_q.k_clk};
    end
  end

  // ---------------------------------------------------------------------------
  // PLL lock model
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] stall_cnt_q;
  logic [CNT_W-1:0] lock_cnt_q;
  logic             stalled;

  // The threshold must exceed the slowest half period in use; a shorter stall
  // is treated as normal clocking, since its length cannot be told apart.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || k_rise || kn_rise) begin
      stall_cnt_q <= '0;
    end else if (!stalled) begin
      stall_cnt_q <= stall_cnt_q + CNT_W'(1);
    end
  end

  assign stalled = (stall_cnt_q >= CNT_W'(STALL_CYC)) &&
                   (stall_cnt_q >= CNT_W'(PLL_RST_MIN_CYC));

  always_ff @(posedge clk_sys) begin
    if (sys_rst || stalled || !pin_q.pll_disable_n) begin
      lock_cnt_q <= '0;
      pll_locked <= 1'b0;
    end else if (lock_cnt_q >= CNT_W'(LOCK_CYC - 1)) begin
      pll_locked <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // Impedance recalibration
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] recal_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      recal_cnt_q          <= '0;
      impedance_cal_strobe <= 1'b0;
      min_impedance_mode   <= 1'b0;
    end else begin
      impedance_cal_strobe <= 1'b0;
      if (k_rise) begin
        if (recal_cnt_q >= CNT_W'(RECAL_CYC - 1)) begin
          recal_cnt_q          <= '0;
          impedance_cal_strobe <= 1'b1;
          min_impedance_mode   <= pin_q.impedance_ref_pin;
        end else begin
          recal_cnt_q <= recal_cnt_q + CNT_W'(1);
        end
      end
    end
  end

endmodule : qbsp_sram_port

// -----------------------------------------------------------------------------
// Two-stage synchroniser for a bundle of pins
// -----------------------------------------------------------------------------
module qbsp_sync2
  import qbsp_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // System clock
  input  wire logic             clk_sys,
  // Raw pins and their synchronised copy
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_q;

  // No reset: both stages settle while reset is held.
  always_ff @(posedge clk_sys) begin
    stage1_q <= din;
    dout     <= stage1_q;
  end

endmodule : qbsp_sync2

// -----------------------------------------------------------------------------
// Rising edge finder for a sampled input clock
// -----------------------------------------------------------------------------
module qbsp_edge_detect
  import qbsp_pkg::*;
(
  // System clock
  input  wire logic clk_sys,
  // Sampled level and its rising edge
  input  wire logic level,
  output logic      rise
);

  logic level_q;

  always_ff @(posedge clk_sys) begin
    level_q <= level;
  end

  assign rise = level & ~level_q;

endmodule : qbsp_edge_detect

/* File: inc/qbsp_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: Shared constants and carriers for the burst-of-two SRAM port.
// Assumes: One system clock at 50 MHz samples the complementary input clocks.
// Notes:   Array depth is kept small so the storage fits in flip-flops.
//------------------------------------------------------------------------------
package qbsp_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 18;
  localparam int unsigned BYTE_W  = 9;
  localparam int unsigned NBYTES  = DATA_W / BYTE_W;
  localparam int unsigned WORDS   = 2 ** (ADDR_W + 1);
  localparam logic        BURST_FIRST  = 1'b0;
  localparam logic        BURST_SECOND = 1'b1;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned PLL_LOCK_US     = 100;
  localparam int unsigned PLL_LOCK_CYC    = (PLL_LOCK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PLL_RST_MIN_NS  = 30;
  localparam int unsigned PLL_RST_MIN_CYC = (PLL_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECAL_PERIOD    = 1024;
  localparam int unsigned CNT_W           = 16;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              k_clk;
    logic              k_clk_n;
    logic [ADDR_W-1:0] addr;
    logic              read_port_select_n;
    logic              write_port_select_n;
    logic [NBYTES-1:0] byte_write_select_n;
    logic [DATA_W-1:0] data;
    logic              pll_disable_n;
    logic              impedance_ref_pin;
  } qbsp_pins_type;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } qbsp_rd_entry_type;

  typedef struct packed {
    logic              pending;
    logic [DATA_W-1:0] data;
    logic [NBYTES-1:0] be_n;
  } qbsp_wr_first_type;

  localparam int unsigned PINS_W = $bits(qbsp_pins_type);
  localparam qbsp_rd_entry_type RD_IDLE = '{valid: 1'b0, addr: '0};

endpackage : qbsp_pkg
